// >>> rtl/mct_timing_top.v
`timescale 1ns/10ps
`default_nettype none
`include "mct_defs.vh"

// What this block does
// - emulation entered: strobe low in reset, program strobe high, strobe low at release
// - emulation: port 0 floats, other ports and both strobes weakly pulled high
// - oscillator keeps running throughout emulation mode
// - emulation left only when a fresh valid reset is applied
// - power-down bit set outside emulation opens oscillator feedback while it stays one
// - machine cycle steps through six states, first to sixth
// - each state lasts two oscillator periods, twelve per machine cycle
// - each state split into phase one and phase two halves
// - address strobe pulses at one sixth osc rate, skipping one per data access
// - reset pin must stay high two machine cycles with oscillator running
// - in power-down outside core reset both strobes driven low
module mct_timing_top (
  input  wire                    i_sys_clk,
  input  wire                    i_rst_b,
  input  wire                    i_rst_pin,
  input  wire                    i_ale_pin,
  input  wire                    i_prog_store_strobe_pin,
  input  wire                    i_power_down_bit,
  input  wire                    i_ext_data_access,
  input  wire                    i_prog_fetch,
  output reg  [`MCT_STATE_W-1:0] o_state,
  output reg                     o_phase2,
  output reg                     o_core_reset,
  output reg                     o_osc_fb_open,
  output reg                     o_emul_mode,
  output reg                     o_ale,
  output reg                     o_ale_oe_b,
  output reg                     o_prog_store_strobe,
  output reg                     o_prog_store_strobe_oe_b,
  output reg                     o_port0_float,
  output reg                     o_ports_weak_pull
);

  // ****************************************
  // reset release and pin synchronisers
  // ****************************************
  reg  rst_m_q;
  reg  rst_n_q;
  wire [2:0] pins_raw;
  wire [2:0] pins_sync;

  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_m_q <= 1'h0;
      rst_n_q <= 1'h0;
    end else begin
      rst_m_q <= 1'h1;
      rst_n_q <= rst_m_q;
    end
  end

  assign pins_raw = {i_prog_store_strobe_pin, i_ale_pin, i_rst_pin};

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_sync
      mct_sync3 u_sync (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (rst_n_q),
        .i_pin     (pins_raw[g]),
        .o_level_q (pins_sync[g])
      );
    end
  endgenerate

  wire rst_pin_s  = pins_sync[0];
  wire ale_pin_s  = pins_sync[1];
  wire prog_store_strobe_pin_s = pins_sync[2];

  // ****************************************
  // oscillator control
  // ****************************************
  reg  emul_q;
  // feedback opens on power-down, never in emulation
  wire osc_stop = i_power_down_bit & ~emul_q;

  // ****************************************
  // reset pin qualification
  // ****************************************
  reg  [`MCT_RST_CNT_W-1:0] rst_cnt_q;
  reg                       core_rst_q;
  reg                       strap_seen_q;

  always @(posedge i_sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rst_cnt_q  <= {`MCT_RST_CNT_W{1'h0}};
      core_rst_q <= 1'h1;
    end else if (!rst_pin_s) begin
      rst_cnt_q  <= {`MCT_RST_CNT_W{1'h0}};
      core_rst_q <= 1'h0;
    end else if (!osc_stop) begin
      if (rst_cnt_q == `MCT_RST_CYCLES - 1) begin
        core_rst_q <= 1'h1;
      end else begin
        rst_cnt_q <= rst_cnt_q + 1'h1;
      end
    end
  end

  // ****************************************
  // emulation entry
  // ****************************************
  always @(posedge i_sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      emul_q       <= `MCT_RST_EMUL;
      strap_seen_q <= 1'h0;
    end else if (core_rst_q) begin
      emul_q <= 1'h0;
      // strap: strobe low with program strobe high
      if (!ale_pin_s && prog_store_strobe_pin_s) begin
        strap_seen_q <= 1'h1;
      end else if (ale_pin_s) begin
        strap_seen_q <= 1'h0;
      end
      // strobe still low as reset drops
      if (!rst_pin_s && strap_seen_q && !ale_pin_s) begin
        emul_q <= 1'h1;
      end
    end else begin
      strap_seen_q <= 1'h0;
    end
  end

  // ****************************************
  // state and phase sequencer
  // ****************************************
  reg [`MCT_STATE_W-1:0] state_q;
  reg                    phase_q;

  // held at first state in reset, frozen while clock stopped
  always @(posedge i_sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= `MCT_STATE_FIRST;
      phase_q <= `MCT_RST_PHASE;
    end else if (core_rst_q) begin
      state_q <= `MCT_STATE_FIRST;
      phase_q <= `MCT_RST_PHASE;
    end else if (!osc_stop) begin
      phase_q <= ~phase_q;
      // advance after phase two, wrap sixth to first
      if (phase_q) begin
        if (state_q == `MCT_STATE_SIXTH) begin
          state_q <= `MCT_STATE_FIRST;
        end else begin
          state_q <= state_q + 1'h1;
        end
      end
    end
  end

  // strobe is high from phase two of its state through phase one of the next
  function ale_window;
    input [`MCT_STATE_W-1:0] st;
    input                    ph;
    input [`MCT_STATE_W-1:0] base;
    begin
      ale_window = (st == base && ph) || (st == base + 3'h1 && !ph);
    end
  endfunction

  // twice per machine cycle; the first slot is skipped on data access
  wire ale_norm = (ale_window(state_q, phase_q, `MCT_ALE_ON_A) & ~i_ext_data_access)
                | ale_window(state_q, phase_q, `MCT_ALE_ON_B);

  // ****************************************
  // output registers
  // ****************************************
  always @(posedge i_sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      o_state                  <= `MCT_STATE_FIRST;
      o_phase2                 <= 1'h0;
      o_core_reset             <= 1'h1;
      o_osc_fb_open            <= 1'h0;
      o_emul_mode              <= 1'h0;
      o_ale                    <= 1'h1;
      o_ale_oe_b               <= 1'h1;
      o_prog_store_strobe      <= 1'h1;
      o_prog_store_strobe_oe_b <= 1'h1;
      o_port0_float            <= 1'h0;
      o_ports_weak_pull        <= 1'h0;
    end else begin
      o_state       <= state_q;
      o_phase2      <= phase_q;
      o_core_reset  <= core_rst_q;
      o_osc_fb_open <= osc_stop;
      o_emul_mode   <= emul_q;
      // float port 0, weak pull on the rest
      o_port0_float     <= emul_q;
      o_ports_weak_pull <= emul_q;
      if (emul_q || core_rst_q) begin
        // weak pull only, so the emulator or strap can win the pins
        o_ale                    <= 1'h1;
        o_ale_oe_b               <= 1'h1;
        o_prog_store_strobe      <= 1'h1;
        o_prog_store_strobe_oe_b <= 1'h1;
      end else if (osc_stop) begin
        o_ale                    <= 1'h0;
        o_ale_oe_b               <= 1'h0;
        o_prog_store_strobe      <= 1'h0;
        o_prog_store_strobe_oe_b <= 1'h0;
      end else begin
        o_ale                    <= ale_norm;
        o_ale_oe_b               <= 1'h0;
        o_prog_store_strobe      <= ~i_prog_fetch;
        o_prog_store_strobe_oe_b <= 1'h0;
      end
    end
  end

endmodule // mct_timing_top

`default_nettype wire

// >>> rtl/mct_defs.vh
`ifndef MCT_DEFS_VH
`define MCT_DEFS_VH

// ****************************************
// machine cycle layout
// ****************************************
`define MCT_STATE_W        3
`define MCT_STATE_FIRST    3'h0
`define MCT_STATE_SIXTH    3'h5
`define MCT_STATES_PER_MC  6
`define MCT_OSC_PER_STATE  2
`define MCT_OSC_PER_MC     (`MCT_STATES_PER_MC * `MCT_OSC_PER_STATE)

// ****************************************
// address latch strobe windows
// ****************************************
`define MCT_ALE_ON_A       3'h0
`define MCT_ALE_ON_B       3'h3

// ****************************************
// reset pin qualification
// ****************************************
`define MCT_RST_MC         2
`define MCT_RST_CYCLES     (`MCT_RST_MC * `MCT_OSC_PER_MC)
`define MCT_RST_CNT_W      5

// ****************************************
// reset values
// ****************************************
`define MCT_RST_PHASE      1'h0
`define MCT_RST_EMUL       1'h0

`endif

// >>> rtl/mct_sync3.v
`timescale 1ns/10ps
`default_nettype none

// three-stage pin synchroniser; output moves only when stages two and three agree
module mct_sync3 (
  input  wire i_sys_clk,
  input  wire i_rst_n,
  input  wire i_pin,
  output reg  o_level_q
);

  reg s1_q;
  reg s2_q;
  reg s3_q;

  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_q      <= 1'h0;
      s2_q      <= 1'h0;
      s3_q      <= 1'h0;
      o_level_q <= 1'h0;
    end else begin
      s1_q <= i_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        o_level_q <= s3_q;
      end
    end
  end

endmodule // mct_sync3

`default_nettype wire

// >>> bench/mct_timing_checker.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// timing and mode checks
// ****************************************
module mct_timing_checker (
  input wire logic       i_sys_clk,
  input wire logic       i_rst_b,
  input wire logic       i_rst_pin,
  input wire logic       i_power_down_bit,
  input wire logic [2:0] o_state,
  input wire logic       o_phase2,
  input wire logic       o_core_reset,
  input wire logic       o_osc_fb_open,
  input wire logic       o_emul_mode,
  input wire logic       o_ale,
  input wire logic       o_ale_oe_b,
  input wire logic       o_prog_store_strobe,
  input wire logic       o_prog_store_strobe_oe_b,
  input wire logic       o_port0_float,
  input wire logic       o_ports_weak_pull
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  // three quiet samples so a freeze lagging by one output cycle never fires
  wire run = !o_core_reset && !o_osc_fb_open && !o_emul_mode && !i_power_down_bit;
  property p_step; run[*3] |-> o_phase2 != $past(o_phase2) && o_state == (o_phase2 ? $past(o_state) :
    ($past(o_state) == 3'h5 ? 3'h0 : $past(o_state) + 3'h1)); endproperty
  a_step: assert property (p_step) else $error("state sequence broken");
  property p_rst_hold; o_core_reset[*3] |-> o_state == 3'h0; endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("state not held in reset");
  property p_pd_stop; (i_power_down_bit && !o_emul_mode)[*3] |-> o_osc_fb_open; endproperty
  a_pd_stop: assert property (p_pd_stop) else $error("oscillator not stopped");
  property p_pd_pins; o_osc_fb_open[*2] |-> !o_ale && !o_prog_store_strobe && !o_ale_oe_b
    && !o_prog_store_strobe_oe_b; endproperty
  a_pd_pins: assert property (p_pd_pins) else $error("strobes not driven low");
  property p_emul_pins; o_emul_mode[*2] |-> o_port0_float && o_ports_weak_pull && o_ale_oe_b
    && o_prog_store_strobe_oe_b; endproperty
  a_emul_pins: assert property (p_emul_pins) else $error("pins not released");
  property p_emul_osc; o_emul_mode[*2] |-> !o_osc_fb_open; endproperty
  a_emul_osc: assert property (p_emul_osc) else $error("oscillator stopped in emulation");
  property p_emul_keep; $fell(o_emul_mode) |-> o_core_reset || $past(o_core_reset); endproperty
  a_emul_keep: assert property (p_emul_keep) else $error("emulation left without reset");
  property p_ale_gap; $rose(o_ale) && !o_ale_oe_b |=> (!$rose(o_ale))[*5]; endproperty
  a_ale_gap: assert property (p_ale_gap) else $error("strobe pulses too close");
  property p_rst_qual; $rose(o_core_reset) |-> $past(i_rst_pin, 8) && $past(i_rst_pin, 26); endproperty
  a_rst_qual: assert property (p_rst_qual) else $error("reset taken too early");
endmodule // mct_timing_checker
bind mct_timing_top mct_timing_checker mct_timing_checker_inst (.*);
`default_nettype wire

// >>> bench/mct_emul_partner.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// board side: reset pin, strap, pin pulls
// ****************************************
module mct_emul_partner (
  input  wire logic       i_sys_clk,
  input  wire logic       i_go,
  input  wire logic [5:0] i_len,
  input  wire logic       i_strap,
  input  wire logic       i_ale,
  input  wire logic       i_ale_oe_b,
  input  wire logic       i_pss,
  input  wire logic       i_pss_oe_b,
  output logic            o_rst_pin,
  output logic            o_ale_pin,
  output logic            o_pss_pin
);
  int   cnt = -9;
  logic strap_q = 1'b0;
  always @(posedge i_sys_clk) begin
    if (i_go) begin
      cnt <= i_len;
      strap_q <= i_strap;
    end else if (cnt > -9) begin
      cnt <= cnt - 1;
    end
  end
  assign o_rst_pin = cnt > 0;
  // strobe low past release, pulls high
  assign o_ale_pin = (strap_q && cnt > -9) ? 1'b0 : (i_ale_oe_b ? 1'b1 : i_ale);
  assign o_pss_pin = i_pss_oe_b ? 1'b1 : i_pss;
endmodule // mct_emul_partner
`default_nettype wire

// >>> bench/machine_cycle_timing_and_emulation_entry_tb.sv
`timescale 1ns/10ps
`default_nettype none
module machine_cycle_timing_and_emulation_entry_tb;
  logic       i_sys_clk = 1'b0, i_rst_b = 1'b0, pd = 1'b0, xda = 1'b0, fetch = 1'b0, go = 1'b0, strap = 1'b0;
  logic [5:0] len = 6'h00;
  wire        rst_pin, ale_pin, pss_pin, ph2, crst, fbo, emul, ale, ale_oe_b, pss, pss_oe_b, p0f, wpu;
  wire  [2:0] state;
  int         err_count = 0, compares = 0, gap = 0;
  logic       ale_q = 1'b1;
  logic [8:0] gap_q[$], st_q[$];
  event       look;
  mct_timing_top mct_timing_top_inst (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_rst_pin(rst_pin),
    .i_ale_pin(ale_pin), .i_prog_store_strobe_pin(pss_pin), .i_power_down_bit(pd), .i_ext_data_access(xda),
    .i_prog_fetch(fetch), .o_state(state), .o_phase2(ph2), .o_core_reset(crst), .o_osc_fb_open(fbo),
    .o_emul_mode(emul), .o_ale(ale), .o_ale_oe_b(ale_oe_b), .o_prog_store_strobe(pss),
    .o_prog_store_strobe_oe_b(pss_oe_b), .o_port0_float(p0f), .o_ports_weak_pull(wpu));
  mct_emul_partner mct_emul_partner_inst (.i_sys_clk(i_sys_clk), .i_go(go), .i_len(len), .i_strap(strap),
    .i_ale(ale), .i_ale_oe_b(ale_oe_b), .i_pss(pss), .i_pss_oe_b(pss_oe_b), .o_rst_pin(rst_pin),
    .o_ale_pin(ale_pin), .o_pss_pin(pss_pin));
  always #25 i_sys_clk = ~i_sys_clk;
  always @(negedge i_sys_clk) fetch <= 1'($urandom_range(0, 1));
  task automatic check(input logic [8:0] seen, input logic [8:0] want);
    compares++;
    if (seen !== want) begin
      err_count++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic results;
    if (err_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic pin_reset(input logic [5:0] n, input logic s);
    len = n;
    strap = s;
    go = 1'b1;
    @(negedge i_sys_clk);
    go = 1'b0;
    repeat (n + 24) @(negedge i_sys_clk);
  endtask
  task automatic expect_st(input logic [8:0] want);
    st_q.push_back(want);
    -> look;
  endtask
  // ****************************************
  // monitors
  // ****************************************
  always @(look)
    check({emul, crst, fbo, p0f, wpu, ale_oe_b, pss_oe_b, fbo ? {ale, pss} : 2'b00},
          st_q.pop_front());
  always @(negedge i_sys_clk) begin
    gap <= gap + 1;
    ale_q <= ale;
    if (ale && !ale_q) begin
      gap <= 1;
      if (gap_q.size() > 0)
        check(9'(gap), gap_q.pop_front());
    end
  end
  initial begin
    void'($urandom(32'h4980936A));
    repeat (3) @(negedge i_sys_clk);
    i_rst_b = 1'b1;
    pin_reset(6'h1E, 1'b0);
    expect_st(9'h000);
    // short pulse leaves strobe rhythm intact
    repeat (6) gap_q.push_back(9'h006);
    pin_reset(6'($urandom_range(4, 18)), 1'b0);
    while (gap_q.size() > 0 || state !== 3'h2) @(negedge i_sys_clk);
    gap_q = '{9'h006, 9'h00C, 9'h006};
    xda = 1'b1;
    repeat (12) @(negedge i_sys_clk);
    xda = 1'b0;
    repeat (24) @(negedge i_sys_clk);
    pd = 1'b1;
    repeat (6) @(negedge i_sys_clk);
    expect_st(9'h040);
    pd = 1'b0;
    repeat (6) @(negedge i_sys_clk);
    expect_st(9'h000);
    pin_reset(6'h1E, 1'b1);
    expect_st(9'h13C);
    pd = 1'b1;
    repeat (6) @(negedge i_sys_clk);
    expect_st(9'h13C);
    pd = 1'b0;
    pin_reset(6'($urandom_range(4, 18)), 1'b0);
    expect_st(9'h13C);
    pin_reset(6'h1E, 1'b0);
    expect_st(9'h000);
    results;
  end
  // run needs well under a thousand cycles; eight thousand means a hang
  initial begin
    #400000;
    err_count++;
    results;
  end
endmodule // machine_cycle_timing_and_emulation_entry_tb
`default_nettype wire
